// file: inc/rls_consts.vh
// Constants of the rule logic sequencer: offsets, fields, reset values, timing
`ifndef RLS_CONSTS_VH
`define RLS_CONSTS_VH

// Counts
`define RLS_RULES        16
`define RLS_FLAGS        16
`define RLS_TIMERS       16
`define RLS_CONDS        3
`define RLS_AI_CH        4

// Timing, in the unit printed, and clock rate
`define RLS_CLK_MHZ      125
`define RLS_BASE_US      600
`define RLS_RULE_US      370
`define RLS_TICK_US      1000

// Register byte offsets
`define RLS_REG_CTRL     12'h000
`define RLS_REG_STATUS   12'h004
`define RLS_REG_FLAGS    12'h008
`define RLS_REG_CYCLES   12'h00C
`define RLS_REG_DOUT     12'h010
`define RLS_REG_RESULT   12'h014
`define RLS_REG_DIN      12'h018
`define RLS_CFG_BASE     4'h1

// Control bits
`define RLS_CTRL_RUN     0
`define RLS_CTRL_MON     1
`define RLS_CTRL_LOADED  2

// Rule word 0 fields
`define RLS_W0_EN        0
`define RLS_W0_OP_LO     1
`define RLS_W0_OP_HI     3
`define RLS_W0_OPOL      8
`define RLS_W0_OTYP_LO   9
`define RLS_W0_OTYP_HI   11
`define RLS_W0_TMODE     12
`define RLS_W0_OIDX_LO   13
`define RLS_W0_OIDX_HI   16

// Condition byte fields (word 1 holds three bytes)
`define RLS_C_EN         0
`define RLS_C_POL        1
`define RLS_C_SRC_LO     2
`define RLS_C_SRC_HI     3
`define RLS_C_IDX_LO     4
`define RLS_C_IDX_HI     7

// Logic operators
`define RLS_OP_AND       3'h0
`define RLS_OP_OR        3'h1
`define RLS_OP_NAND      3'h2
`define RLS_OP_NOR       3'h3
`define RLS_OP_XOR       3'h4

// Condition sources
`define RLS_SRC_DI       2'h0
`define RLS_SRC_FLAG     2'h1
`define RLS_SRC_AI       2'h2
`define RLS_SRC_TMR      2'h3

// Output targets
`define RLS_OT_NONE      3'h0
`define RLS_OT_DO        3'h1
`define RLS_OT_FLAG      3'h2
`define RLS_OT_REMOTE    3'h3
`define RLS_OT_TIMER     3'h4

// Reset values
`define RLS_FLAGS_RST    16'h0000
`define RLS_DOUT_RST     16'h0000

`endif

// file: core/rls_sync.v
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module rls_sync #(
	parameter W = 16
)(
	input  wire         clk_i,   // System clock
	input  wire         rst_i,   // Synchronous reset
	input  wire [W-1:0] async_i, // Pin levels
	output reg  [W-1:0] sync_o   // Filtered levels
);
	reg [W-1:0] s1;
	reg [W-1:0] s2;
	reg [W-1:0] s3;
	genvar g;

	always @(posedge clk_i) begin
		s1 <= async_i;
		s2 <= s1;
		s3 <= s2;
	end

	// Stage one feeds stage two only; the filter looks at two and three
	generate
		for (g = 0; g < W; g = g + 1) begin : g_bit
			always @(posedge clk_i) begin
				if (rst_i)
					sync_o[g] <= 1'b0;
				else if (s2[g] == s3[g])
					sync_o[g] <= s3[g];
			end
		end
	endgenerate
endmodule
`default_nettype wire

// file: core/rls_timer.v
// Bank of sixteen local timers counting timebase ticks
`timescale 1ns/100ps
`default_nettype none
`include "rls_consts.vh"
module rls_timer (
	input  wire         clk_i,   // System clock
	input  wire         rst_i,   // Synchronous reset
	input  wire         tick_i,  // Timebase pulse
	input  wire         upd_i,   // Update run state
	input  wire [3:0]   idx_i,   // Timer to update
	input  wire         run_i,   // New run state
	output wire [255:0] count_o  // Sixteen 16-bit counts
);
	reg [15:0] cnt [0:`RLS_TIMERS-1];
	reg [`RLS_TIMERS-1:0] run;
	genvar g;

	generate
		for (g = 0; g < `RLS_TIMERS; g = g + 1) begin : g_tmr
			wire hit = upd_i && ({28'h0000000, idx_i} == g);
			always @(posedge clk_i) begin
				if (rst_i) begin
					run[g] <= 1'b0;
					cnt[g] <= 16'h0000;
				end else begin
					if (hit)
						run[g] <= run_i;
					// Stopping clears the count at once
					if (hit && !run_i)
						cnt[g] <= 16'h0000;
					else if (run[g] && tick_i && cnt[g] != 16'hFFFF)
						cnt[g] <= cnt[g] + 16'h0001;
				end
			end
			assign count_o[g*16 +: 16] = cnt[g];
		end
	endgenerate
endmodule
`default_nettype wire

// file: core/rls_top.v
// Rule logic sequencer: sixteen rule slots run in three phases per cycle
//
// Local design decisions: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "rls_consts.vh"
module rls_top #(
	parameter [31:0] P_BASE_CYC = `RLS_BASE_US * `RLS_CLK_MHZ, // Cycle base time
	parameter [31:0] P_RULE_CYC = `RLS_RULE_US * `RLS_CLK_MHZ, // Time per rule
	parameter [31:0] P_TICK_CYC = `RLS_TICK_US * `RLS_CLK_MHZ  // Timer timebase
)(
	input  wire         clk_i,        // System clock, 125 MHz
	input  wire         rst_i,        // Synchronous reset, high
	input  wire         wb_cyc_i,     // Wishbone cycle
	input  wire         wb_stb_i,     // Wishbone strobe
	input  wire         wb_we_i,      // Wishbone write enable
	input  wire [11:0]  wb_adr_i,     // Wishbone byte address
	input  wire [3:0]   wb_sel_i,     // Wishbone byte selects
	input  wire [31:0]  wb_dat_i,     // Wishbone write data
	output reg  [31:0]  wb_dat_o,     // Wishbone read data
	output reg          wb_ack_o,     // Wishbone acknowledge
	input  wire [15:0]  di_i,         // Digital input pins
	input  wire [63:0]  ai_i,         // Four 16-bit analog samples
	output reg  [15:0]  do_o,         // Digital outputs
	input  wire         rmt_in_wr_i,  // Peer flag write strobe
	input  wire [3:0]   rmt_in_idx_i, // Peer flag index
	input  wire         rmt_in_val_i, // Peer flag value
	output reg          rmt_wr_o,     // Remote flag write strobe
	output reg  [3:0]   rmt_idx_o,    // Remote flag index
	output reg          rmt_val_o,    // Remote flag value
	output wire         running_o     // Engine running
);
	localparam [4:0] S_IDLE  = 5'h01;
	localparam [4:0] S_LOGIC = 5'h02;
	localparam [4:0] S_EXEC  = 5'h04;
	localparam [4:0] S_OUT   = 5'h08;
	localparam [4:0] S_WAIT  = 5'h10;

	reg  [31:0] cfg [0:63];
	reg  [15:0] internal_flag_store;
	reg  [15:0] next_flags;
	reg  [15:0] res_logic;
	reg  [15:0] res_exec;
	reg  [4:0]  state;
	reg  [3:0]  slot;
	reg         running;
	reg         mon_en;
	reg         loaded;
	reg  [31:0] cyc_cnt;
	reg  [31:0] cycles_done;
	reg  [31:0] tick_cnt;
	reg         tick;
	reg  [4:0]  n_en;
	reg  [31:0] rd_data;
	integer     k;
	// Clocked write loop has its own index; k belongs to the pacing sum
	integer     j;

	wire [15:0]  di_s;
	wire [255:0] tmr_cnt;

	rls_sync #(
		.W(16)
	) rls_sync_i (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.async_i(di_i),
		.sync_o (di_s)
	);

	// Bus decode
	wire        bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire        bus_wr   = bus_req && wb_we_i;
	wire        cfg_hit  = (wb_adr_i[11:8] == `RLS_CFG_BASE);
	wire [5:0]  cfg_widx = wb_adr_i[7:2];
	wire        ctrl_wr  = bus_wr && (wb_adr_i == `RLS_REG_CTRL) && wb_sel_i[0];
	wire        monitor  = running && mon_en;
	wire        flag_tog = bus_wr && (wb_adr_i == `RLS_REG_FLAGS) && monitor;
	// Configuration cannot change under a running engine
	wire        cfg_wr   = bus_wr && cfg_hit && !running;

	// Current slot's configuration
	wire [31:0] w0 = cfg[{slot, 2'b00}];
	wire [31:0] w1 = cfg[{slot, 2'b01}];
	wire [31:0] w2 = cfg[{slot, 2'b10}];
	wire [31:0] w3 = cfg[{slot, 2'b11}];
	wire        r_en = w0[`RLS_W0_EN];
	wire [2:0]  r_op = w0[`RLS_W0_OP_HI:`RLS_W0_OP_LO];
	wire        o_pol = w0[`RLS_W0_OPOL];
	wire [2:0]  o_typ = w0[`RLS_W0_OTYP_HI:`RLS_W0_OTYP_LO];
	wire        o_tmd = w0[`RLS_W0_TMODE];
	wire [3:0]  o_idx = w0[`RLS_W0_OIDX_HI:`RLS_W0_OIDX_LO];

	// Three input conditions per rule
	wire [2:0] c_en;
	wire [2:0] c_val;
	genvar g;
	generate
		for (g = 0; g < `RLS_CONDS; g = g + 1) begin : g_cond
			wire [7:0]  cb  = w1[g*8 +: 8];
			wire [1:0]  src = cb[`RLS_C_SRC_HI:`RLS_C_SRC_LO];
			wire [3:0]  idx = cb[`RLS_C_IDX_HI:`RLS_C_IDX_LO];
			wire [15:0] ai  = ai_i[idx[1:0]*16 +: 16];
			wire [15:0] tv  = tmr_cnt[idx*16 +: 16];
			reg         raw;
			always @* begin
				case (src)
					`RLS_SRC_DI:   raw = di_s[idx];
					`RLS_SRC_FLAG: raw = internal_flag_store[idx];
					`RLS_SRC_AI:   raw = (ai >= w2[15:0]) && (ai <= w2[31:16]);
					default:       raw = (tv >= w3[15:0]);
				endcase
			end
			assign c_en[g]  = cb[`RLS_C_EN];
			// Polarity bit clear means the input is inverted
			assign c_val[g] = cb[`RLS_C_POL] ? raw : ~raw;
		end
	endgenerate

	// Disabled conditions drop out of the operator
	wire any_en  = |c_en;
	wire and_all = any_en && &(~c_en | c_val);
	wire or_any  = |(c_en & c_val);
	wire xor_all = ^(c_en & c_val);
	reg  logic_res;
	always @* begin
		case (r_op)
			`RLS_OP_AND:  logic_res = and_all;
			`RLS_OP_OR:   logic_res = or_any;
			`RLS_OP_NAND: logic_res = ~and_all;
			`RLS_OP_NOR:  logic_res = ~or_any;
			`RLS_OP_XOR:  logic_res = xor_all;
			default:      logic_res = 1'b0;
		endcase
	end

	// Output stage actions
	wire ex_res   = res_exec[slot];
	wire out_val  = ex_res ? o_pol : ~o_pol;
	wire out_act  = (state == S_OUT) && r_en;
	wire tmr_upd  = out_act && (o_typ == `RLS_OT_TIMER);
	wire tmr_run  = o_tmd ? ~ex_res : ex_res;

	// Timer actions land in the output phase like any other rule output
	rls_timer rls_timer_i (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.tick_i (tick),
		.upd_i  (tmr_upd),
		.idx_i  (o_idx),
		.run_i  (tmr_run),
		.count_o(tmr_cnt)
	);

	// Pacing target for one cycle
	// Rule memory has no reset, so this is meaningful only once loaded
	always @* begin
		n_en = 5'h00;
		for (k = 0; k < `RLS_RULES; k = k + 1)
			n_en = n_en + {4'h0, cfg[k*4][`RLS_W0_EN]};
	end
	wire [31:0] cyc_target = P_BASE_CYC + P_RULE_CYC * {27'h0, n_en};

	// Timer timebase
	always @(posedge clk_i) begin
		if (rst_i) begin
			tick_cnt <= 32'h00000000;
			tick     <= 1'b0;
		end else if (tick_cnt >= P_TICK_CYC - 32'h00000001) begin
			tick_cnt <= 32'h00000000;
			tick     <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 32'h00000001;
			tick     <= 1'b0;
		end
	end

	// Control register
	always @(posedge clk_i) begin
		if (rst_i) begin
			running <= 1'b0;
			mon_en  <= 1'b0;
			loaded  <= 1'b0;
		end else begin
			if (cfg_wr)
				loaded <= 1'b0;
			else if (ctrl_wr && wb_dat_i[`RLS_CTRL_LOADED])
				loaded <= 1'b1;
			if (ctrl_wr) begin
				// Run is granted only after a completed download
				running <= wb_dat_i[`RLS_CTRL_RUN] && (loaded || wb_dat_i[`RLS_CTRL_LOADED]);
				mon_en  <= wb_dat_i[`RLS_CTRL_MON];
			end
		end
	end

	// Rule memory writes, byte by byte
	always @(posedge clk_i) begin
		if (cfg_wr) begin
			for (j = 0; j < 4; j = j + 1)
				if (wb_sel_i[j])
					cfg[cfg_widx][j*8 +: 8] <= wb_dat_i[j*8 +: 8];
		end
	end

	// Sequencer
	always @(posedge clk_i) begin
		if (rst_i) begin
			state       <= S_IDLE;
			slot        <= 4'h0;
			res_logic   <= 16'h0000;
			res_exec    <= 16'h0000;
			cyc_cnt     <= 32'h00000000;
			cycles_done <= 32'h00000000;
		end else if (!running) begin
			state <= S_IDLE;
			slot  <= 4'h0;
		end else begin
			cyc_cnt <= cyc_cnt + 32'h00000001;
			case (state)
				S_IDLE: begin
					state   <= S_LOGIC;
					slot    <= 4'h0;
					cyc_cnt <= 32'h00000000;
				end
				S_LOGIC: begin
					if (r_en)
						res_logic[slot] <= logic_res;
					slot <= slot + 4'h1;
					if (slot == 4'hF)
						state <= S_EXEC;
				end
				S_EXEC: begin
					if (r_en)
						res_exec[slot] <= res_logic[slot];
					slot <= slot + 4'h1;
					if (slot == 4'hF)
						state <= S_OUT;
				end
				S_OUT: begin
					slot <= slot + 4'h1;
					if (slot == 4'hF)
						state <= S_WAIT;
				end
				S_WAIT: begin
					// One local rule stays under 1 ms at the default pacing
					if (cyc_cnt >= cyc_target - 32'h00000001) begin
						state       <= S_LOGIC;
						cyc_cnt     <= 32'h00000000;
						cycles_done <= cycles_done + 32'h00000001;
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	// Flag store: host toggle, then peer write, then own output phase
	always @* begin
		next_flags = internal_flag_store;
		if (flag_tog)
			next_flags = next_flags ^ wb_dat_i[15:0];
		if (rmt_in_wr_i)
			next_flags[rmt_in_idx_i] = rmt_in_val_i;
		if (out_act && o_typ == `RLS_OT_FLAG)
			next_flags[o_idx] = out_val;
	end

	always @(posedge clk_i) begin
		if (rst_i)
			internal_flag_store <= `RLS_FLAGS_RST;
		else
			internal_flag_store <= next_flags;
	end

	// Digital outputs and remote flag writes
	always @(posedge clk_i) begin
		if (rst_i) begin
			do_o      <= `RLS_DOUT_RST;
			rmt_wr_o  <= 1'b0;
			rmt_idx_o <= 4'h0;
			rmt_val_o <= 1'b0;
		end else begin
			if (out_act && o_typ == `RLS_OT_DO)
				do_o[o_idx] <= out_val;
			rmt_wr_o <= out_act && (o_typ == `RLS_OT_REMOTE);
			if (out_act && o_typ == `RLS_OT_REMOTE) begin
				rmt_idx_o <= o_idx;
				rmt_val_o <= out_val;
			end
		end
	end

	// Status layout: slot, one-hot state, monitor, loaded, running
	wire [11:0] status_bits = {slot, state, monitor, loaded, running};

	// Register read mux; unmapped addresses read zero
	always @* begin
		rd_data = 32'h00000000;
		if (cfg_hit)
			rd_data = cfg[cfg_widx];
		else begin
			case (wb_adr_i)
				`RLS_REG_CTRL:   rd_data = {29'h0, loaded, mon_en, running};
				`RLS_REG_STATUS: rd_data = {20'h00000, status_bits};
				`RLS_REG_FLAGS:  rd_data = {16'h0, internal_flag_store};
				`RLS_REG_CYCLES: rd_data = cycles_done;
				`RLS_REG_DOUT:   rd_data = {16'h0, do_o};
				`RLS_REG_RESULT: rd_data = {16'h0, res_exec};
				`RLS_REG_DIN:    rd_data = {16'h0, di_s};
				default:         rd_data = 32'h00000000;
			endcase
		end
	end

	// One wait state; ack drops the cycle after it rose
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= bus_req;
			if (bus_req && !wb_we_i)
				wb_dat_o <= rd_data;
		end
	end

	assign running_o = running;
endmodule
`default_nettype wire

// file: testbench/rls_props.sv
// Assertion checker for the rule logic sequencer top
`timescale 1ns/100ps
`default_nettype none
module rls_props (
	input wire logic        clk_i,    // Clock
	input wire logic        rst_i,    // Reset
	input wire logic        wb_cyc_i, // Bus cycle
	input wire logic        wb_stb_i, // Bus strobe
	input wire logic        wb_we_i,  // Bus write
	input wire logic [11:0] wb_adr_i, // Bus address
	input wire logic [31:0] wb_dat_o, // Read data
	input wire logic        wb_ack_o, // Acknowledge
	input wire logic [15:0] do_o,     // Outputs
	input wire logic        rmt_wr_o, // Remote strobe
	input wire logic        running_o // Running
);
	logic [15:0] run_cnt;
	// Saturates so a long run never wraps into a false early count
	always @(posedge clk_i)
		if (rst_i || !running_o)
			run_cnt <= 16'h0000;
		else if (run_cnt != 16'hFFFF)
			run_cnt <= run_cnt + 16'h0001;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	AST_ACK_REQ: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acknowledged");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	AST_DAT_HOLD: assert property ($changed(wb_dat_o) |-> $past(wb_cyc_i && wb_stb_i && !wb_we_i))
		else $error("read data moved without a read");
	AST_RUN_CAUSE: assert property ($rose(running_o) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 12'h000))
		else $error("run started without control write");
	AST_DO_RUN: assert property ($changed(do_o) |-> $past(running_o))
		else $error("outputs moved while idle");
	AST_DO_ORDER: assert property ($changed(do_o) |-> run_cnt >= 16'h0020)
		else $error("output before logic and execution phases");
	AST_RMT_QUIET: assert property (!running_o [*3] |-> !rmt_wr_o)
		else $error("remote write while idle");
	AST_RST_CLEAR: assert property ($fell(rst_i) |-> !running_o && do_o == 16'h0000 && !rmt_wr_o)
		else $error("outputs not cleared by reset");
	cover property ($rose(running_o));
	cover property (rmt_wr_o);
	cover property ($changed(do_o));
endmodule
bind rls_top rls_props rls_props_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .do_o(do_o), .rmt_wr_o(rmt_wr_o), .running_o(running_o));
`default_nettype wire

// file: testbench/rls_peer.sv
// Peer module model: takes remote flag writes, sends its own
`timescale 1ns/100ps
`default_nettype none
module rls_peer (
	input  wire logic        clk_i,   // Clock
	input  wire logic        rst_i,   // Reset
	input  wire logic        wr_i,    // Write in
	input  wire logic [3:0]  idx_i,   // Index in
	input  wire logic        val_i,   // Value in
	input  wire logic        send_i,  // Bench request
	input  wire logic [3:0]  sidx_i,  // Index to send
	input  wire logic        sval_i,  // Value to send
	output logic      [15:0] flags_o, // Peer flags
	output logic             wr_o,    // Write out
	output logic      [3:0]  idx_o,   // Index out
	output logic             val_o    // Value out
);
	always @(posedge clk_i)
		if (rst_i) begin
			flags_o <= 16'h0000;
			wr_o <= 1'b0;
			idx_o <= 4'h0;
			val_o <= 1'b0;
		end else begin
			wr_o <= send_i;
			// Released lines toggle so a stale value is never taken
			idx_o <= send_i ? sidx_i : ~idx_o;
			val_o <= send_i ? sval_i : ~val_o;
			if (wr_i)
				flags_o[idx_i] <= val_i;
		end
endmodule
`default_nettype wire

// file: testbench/rls_top_tb.sv
// Self-checking bench for the rule logic sequencer
`timescale 1ns/100ps
`default_nettype none
module rls_top_tb;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0;
	logic        we = 1'b0;
	logic [11:0] adr = 12'h000;
	logic [31:0] wdat = 32'h00000000;
	logic [31:0] wb_dat_o, rdat;
	logic        wb_ack_o, rmt_wr_o, rmt_val_o, pwr, pval, running_o;
	logic [15:0] di_i = 16'h0000;
	logic [63:0] ai_i = 64'h0000000000000000;
	logic [15:0] do_o, pflags, seed, d, a;
	logic [3:0]  rmt_idx_o, pidx, sidx = 4'h0;
	logic        send = 1'b0;
	logic [31:0] exp_q[$], msk_q[$], t0[12], t1[12];
	int          miscompares = 0;
	int          cmp_count = 0;
	always #4 clk_i = ~clk_i;
	rls_top #(.P_BASE_CYC(32'h40), .P_RULE_CYC(32'h4), .P_TICK_CYC(32'h14)) rls_top_i (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .di_i(di_i), .ai_i(ai_i), .do_o(do_o), .rmt_in_wr_i(pwr),
		.rmt_in_idx_i(pidx), .rmt_in_val_i(pval), .rmt_wr_o(rmt_wr_o),
		.rmt_idx_o(rmt_idx_o), .rmt_val_o(rmt_val_o), .running_o(running_o));
	rls_peer rls_peer_i (.clk_i(clk_i), .rst_i(rst_i), .wr_i(rmt_wr_o), .idx_i(rmt_idx_o),
		.val_i(rmt_val_o), .send_i(send), .sidx_i(sidx), .sval_i(1'b1), .flags_o(pflags),
		.wr_o(pwr), .idx_o(pidx), .val_o(pval));
	function automatic [15:0] lfsr(input [15:0] s);
		lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic [31:0] rw(input [2:0] op, input [2:0] ot, input [3:0] ix);
		rw = {15'h0000, ix, 1'b0, ot, 1'b1, 4'h0, op, 1'b1};
	endfunction
	function automatic [7:0] cb(input [1:0] src, input [3:0] ix, input pol);
		cb = {ix, src, pol, 1'b1};
	endfunction
	task summarize;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input [31:0] s, input [31:0] e);
		cmp_count++;
		if (s !== e) begin
			miscompares++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// Read results are checked by the monitor from the noted queue
	task automatic wb(input [11:0] ad, input w, input [31:0] dt, input [31:0] e, input [31:0] m);
		int n;
		if (!w) begin
			exp_q.push_back(e & m);
			msk_q.push_back(m);
		end
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= ad;
		wdat <= dt;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20) begin
			miscompares++;
			summarize();
		end
		rdat = wb_dat_o;
		cyc <= 1'b0;
	endtask
	always @(posedge clk_i)
		if (wb_ack_o === 1'b1 && cyc && !we) begin
			if (exp_q.size() == 0) begin
				miscompares++;
				$display("[FAIL] t=%0t seen=%h exp=%h", $time, wb_dat_o, 32'h00000000);
			end else
				chk(wb_dat_o & msk_q.pop_front(), exp_q.pop_front());
		end
	task automatic until_cyc(input [31:0] c);
		int n;
		n = 0;
		rdat = 32'hFFFFFFFF;
		while (rdat !== c && n < 400) begin
			wb(12'h00C, 1'b0, 32'h0, 32'h0, 32'h0);
			n++;
		end
		if (n >= 400) begin
			miscompares++;
			summarize();
		end
	endtask
	task apply;
		seed = lfsr(seed);
		d = seed;
		seed = lfsr(seed);
		a = seed;
		di_i <= d;
		ai_i <= {d, seed, d, a};
	endtask
	initial begin
		seed = 16'h9528;
		t0 = '{rw(3'h0, 3'h2, 4'h0), rw(3'h0, 3'h2, 4'h1), rw(3'h1, 3'h1, 4'h0),
			rw(3'h2, 3'h2, 4'h2), rw(3'h4, 3'h3, 4'h5), rw(3'h1, 3'h1, 4'h1) & 32'hFFFFFFFE,
			rw(3'h0, 3'h1, 4'h2), rw(3'h3, 3'h1, 4'h3), rw(3'h0, 3'h4, 4'h0),
			rw(3'h0, 3'h1, 4'h4), rw(3'h0, 3'h4, 4'h1) | 32'h00001000, rw(3'h0, 3'h1, 4'h5)};
		t1 = '{{24'h0, cb(2'h0, 4'h0, 1'b1)}, {24'h0, cb(2'h0, 4'h1, 1'b1)},
			{16'h0, cb(2'h1, 4'h1, 1'b1), cb(2'h1, 4'h0, 1'b1)}, {24'h0, cb(2'h1, 4'h2, 1'b1)},
			{24'h0, cb(2'h0, 4'h2, 1'b0)}, {16'h0, cb(2'h0, 4'h0, 1'b0), cb(2'h0, 4'h0, 1'b1)},
			{24'h0, cb(2'h2, 4'h0, 1'b1)},
			{8'h0, cb(2'h0, 4'h5, 1'b1), cb(2'h0, 4'h4, 1'b1), cb(2'h0, 4'h3, 1'b1)},
			{24'h0, cb(2'h0, 4'h0, 1'b1)}, {24'h0, cb(2'h3, 4'h0, 1'b1)},
			{24'h0, cb(2'h0, 4'h0, 1'b1)}, {24'h0, cb(2'h3, 4'h1, 1'b1)}};
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(12'h000, 1'b0, 32'h0, 32'h0, 32'hFFFFFFFF);
		wb(12'h004, 1'b0, 32'h0, 32'h8, 32'hFF);
		wb(12'h008, 1'b0, 32'h0, 32'h0, 32'hFFFF);
		wb(12'h010, 1'b0, 32'h0, 32'h0, 32'hFFFF);
		wb(12'h0FC, 1'b0, 32'h0, 32'h0, 32'hFFFFFFFF);
		wb(12'h000, 1'b1, 32'h1, 32'h0, 32'h0);
		wb(12'h004, 1'b0, 32'h0, 32'h0, 32'h1);
		$display("reset and idle tests done");
		for (int r = 0; r < 16; r++) begin
			wb({4'h1, r[3:0], 4'h0}, 1'b1, r < 12 ? t0[r] : 32'h0, 32'h0, 32'h0);
			wb({4'h1, r[3:0], 4'h4}, 1'b1, r < 12 ? t1[r] : 32'h0, 32'h0, 32'h0);
		end
		wb(12'h168, 1'b1, 32'hBFFF4000, 32'h0, 32'h0);
		wb(12'h19C, 1'b1, 32'h2, 32'h0, 32'h0);
		wb(12'h1BC, 1'b1, 32'h2, 32'h0, 32'h0);
		apply;
		repeat (8) @(posedge clk_i);
		wb(12'h000, 1'b1, 32'h5, 32'h0, 32'h0);
		wb(12'h004, 1'b0, 32'h0, 32'h3, 32'h3);
		until_cyc(32'h1);
		wb(12'h008, 1'b0, 32'h0, {29'h0, 1'b1, d[1:0]}, 32'h7);
		wb(12'h010, 1'b0, 32'h0, 32'h0, 32'h1);
		until_cyc(32'h2);
		wb(12'h008, 1'b0, 32'h0, 32'h0, 32'h4);
		wb(12'h010, 1'b0, 32'h0, {31'h0, d[0] | d[1]}, 32'h1);
		$display("cascade and feedback tests done");
		wb(12'h008, 1'b1, 32'h200, 32'h0, 32'h0);
		wb(12'h008, 1'b0, 32'h0, 32'h0, 32'h200);
		wb(12'h000, 1'b1, 32'h7, 32'h0, 32'h0);
		wb(12'h008, 1'b1, 32'h200, 32'h0, 32'h0);
		wb(12'h008, 1'b0, 32'h0, 32'h200, 32'h200);
		sidx <= 4'hA;
		send <= 1'b1;
		@(posedge clk_i);
		send <= 1'b0;
		wb(12'h008, 1'b0, 32'h0, 32'h400, 32'h400);
		// Ignored while running, so DO0 must keep its OR result below
		wb(12'h120, 1'b1, 32'h0, 32'h0, 32'h0);
		$display("host and peer flag tests done");
		repeat (3) begin
			apply;
			repeat (600) @(posedge clk_i);
			wb(12'h010, 1'b0, 32'h0, {26'h0, ~d[0], d[0], ~(d[3] | d[4] | d[5]),
				a >= 16'h4000 && a <= 16'hBFFF, 1'b0, d[0] | d[1]}, 32'h3F);
			chk({31'h0, pflags[5]}, {31'h0, ~d[2]});
			wb(12'h014, 1'b0, 32'h0, {20'h0, ~d[0], d[0], d[0], d[0], ~(d[3] | d[4] | d[5]),
				a >= 16'h4000 && a <= 16'hBFFF, 1'b0, ~d[2], 1'b0, d[0] | d[1], d[1:0]},
				32'hFF7);
			wb(12'h018, 1'b0, 32'h0, {16'h0, d}, 32'hFFFF);
		end
		$display("random input rounds done");
		wb(12'h000, 1'b1, 32'h0, 32'h0, 32'h0);
		wb(12'h004, 1'b0, 32'h0, 32'h0, 32'h1);
		$display("stop test done");
		summarize();
	end
endmodule
`default_nettype wire
